//--- rtl/ccp_core_clock_power.sv
// Core clock and power mode controller top
// Summary of operation
// - PLL locks at 1275 times 32.768 kHz reference giving 41.78 MHz.
// - Core clock is PLL clock divided by two to the divider setting.
// - After reset the divider setting is three, PLL divided by eight.
// - Core clock may come from the external clock input instead.
// - Software-writable source select; reset picks internal oscillator.
// - On lost lock while the PLL is enabled and feeds the core, halt core clock at once and raise PLL interrupt.
// - Reset status records watchdog reset until cleared; resetn also clears it.
// - Five modes, each stopping more domains: active to stop.
// - Pause wakes in 230 ns to 3 us; sleep 1.23 ms; stop 1.45 ms.
// - Nap wakes in 283 ns to 3 us with PLL kept running.
`default_nettype none
module ccp_core_clock_power
	import ccp_pkg::*;
#(
	parameter int unsigned SLEEP_CYC = SLEEP_WAKE_CYC,
	parameter int unsigned STOP_CYC  = STOP_WAKE_CYC
) (
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	input  wire logic         pll_system_clock_tick,
	input  wire logic         external_clock_input_tick,
	input  wire logic         pll_locked,
	input  wire logic         ctrl_wr,
	input  wire ccp_pkg::ccp_ctrl_t ctrl_wdata,
	input  wire logic         mode_wr,
	input  wire ccp_pkg::ccp_mode_t mode_wdata,
	input  wire logic         wake_req,
	input  wire logic         wdog_reset_seen,
	input  wire logic         rst_status_clr,
	output ccp_pkg::ccp_ctrl_t pll_control_register,
	output ccp_pkg::ccp_mode_t mode,
	output ccp_pkg::ccp_pwr_t pwr,
	output logic              pll_ref_watch_crystal_oscillator,
	output logic              core_clock_tick,
	output logic              pll_irq,
	output logic              reset_status_register,
	output logic              waking
);
	typedef struct packed {
		ccp_ctrl_t        ctrl;
		ccp_mode_t        mode;
		ccp_pwr_t         pwr;
		logic             ref_watch_crystal_oscillator;
		logic             ext_sel;
		logic             core_tick;
		logic             irq;
		logic             wdog;
		logic             waking;
		logic [CNT_W-1:0] wake_cnt;
	} ccp_st_t;

	ccp_st_t st;
	ccp_st_t next_st;
	logic    div_tick;
	logic    src_tick;
	logic [CNT_W-1:0] wake_len;

	localparam ccp_ctrl_t CTRL_RESET = '{src: CCP_REF_INTOSC,
		core_clock_divider: DIV_RESET};
	localparam ccp_pwr_t PWR_ALL = 5'h1F;

	// binary division of the PLL clock
	ccp_divider #(
		.W(8)
	) u_div (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.tick_in  (pll_system_clock_tick),
		.div_sel  (st.ctrl.core_clock_divider),
		.tick_out (div_tick)
	);

	// external input or divided PLL, chosen by registered select
	assign src_tick = st.ext_sel ? external_clock_input_tick : div_tick;

	// pause and nap wake length scales with divider between the two endpoints
	always_comb begin
		wake_len = CNT_ONE;
		unique case (st.mode)
			CCP_PAUSE: wake_len = CNT_W'(PAUSE_WAKE0_CYC
				+ ((WAKE7_CYC - PAUSE_WAKE0_CYC)
				* st.ctrl.core_clock_divider) / DIV_MAX);
			CCP_NAP: wake_len = CNT_W'(NAP_WAKE0_CYC
				+ ((WAKE7_CYC - NAP_WAKE0_CYC)
				* st.ctrl.core_clock_divider) / DIV_MAX);
			CCP_SLEEP: wake_len = CNT_W'(SLEEP_CYC);
			CCP_STOP:  wake_len = CNT_W'(STOP_CYC);
			CCP_ACTIVE: wake_len = CNT_ONE;
		endcase
	end

	always_comb begin
		next_st = st;
		if (ctrl_wr) begin
			next_st.ctrl = ctrl_wdata;
		end
		next_st.ref_watch_crystal_oscillator = (st.ctrl.src == CCP_REF_WATCH_CRYSTAL_OSCILLATOR);
		// source swaps on a source clock boundary, or at once while the core is off
		if (src_tick || !st.pwr.core_en) begin
			next_st.ext_sel = (st.ctrl.src == CCP_SRC_EXT);
		end
		// entering a low power mode from active
		if (mode_wr && st.mode == CCP_ACTIVE && !st.waking) begin
			next_st.mode = mode_wdata;
		end
		if (st.mode != CCP_ACTIVE && wake_req && !st.waking) begin
			next_st.waking = 1'b1;
			next_st.wake_cnt = wake_len;
		end
		if (st.waking) begin
			if (st.wake_cnt <= CNT_ONE) begin
				next_st.waking = 1'b0;
				next_st.wake_cnt = CNT_ZERO;
				next_st.mode = CCP_ACTIVE;
			end else begin
				next_st.wake_cnt = st.wake_cnt - CNT_ONE;
			end
		end
		next_st.pwr = PWR_ALL;
		unique case (next_st.mode)
			CCP_ACTIVE: next_st.pwr = PWR_ALL;
			CCP_PAUSE:  next_st.pwr.core_en = 1'b0;
			CCP_NAP: begin
				next_st.pwr.core_en = 1'b0;
				next_st.pwr.periph_en = 1'b0;
			end
			CCP_SLEEP: begin
				next_st.pwr.core_en = 1'b0;
				next_st.pwr.periph_en = 1'b0;
				next_st.pwr.pll_en = 1'b0;
			end
			CCP_STOP: begin
				next_st.pwr.core_en = 1'b0;
				next_st.pwr.periph_en = 1'b0;
				next_st.pwr.pll_en = 1'b0;
				next_st.pwr.watch_crystal_oscillator_timer_en = 1'b0;
			end
		endcase
		// halt core clock while unlocked, PLL in use
		next_st.core_tick = src_tick && st.pwr.core_en
			&& (st.ext_sel || pll_locked);
		next_st.irq = !pll_locked && st.pwr.pll_en && !st.ext_sel;
		// sticky watchdog flag; set beats clear
		if (rst_status_clr) begin
			next_st.wdog = 1'b0;
		end
		if (wdog_reset_seen) begin
			next_st.wdog = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			st <= '{ctrl: CTRL_RESET, mode: CCP_ACTIVE, pwr: PWR_ALL,
				ref_watch_crystal_oscillator: 1'b0, ext_sel: 1'b0, core_tick: 1'b0,
				irq: 1'b0, wdog: 1'b0, waking: 1'b0,
				wake_cnt: CNT_ZERO};
		end else begin
			st <= next_st;
		end
	end

	assign pll_control_register  = st.ctrl;
	assign mode                  = st.mode;
	assign pwr                   = st.pwr;
	assign pll_ref_watch_crystal_oscillator          = st.ref_watch_crystal_oscillator;
	assign core_clock_tick       = st.core_tick;
	assign pll_irq               = st.irq;
	assign reset_status_register = st.wdog;
	assign waking                = st.waking;
endmodule
`default_nettype wire

//--- rtl/ccp_divider.sv
// Glitch-free binary core clock enable divider
`default_nettype none
module ccp_divider
	import ccp_pkg::*;
#(
	parameter int unsigned W = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	input  wire logic         tick_in,
	input  wire logic [2:0]   div_sel,
	output logic              tick_out
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic [2:0]   sel;
		logic         tick;
	} ccp_div_st_t;

	ccp_div_st_t st;
	ccp_div_st_t next_st;
	logic [W-1:0] mask;

	always_comb begin
		next_st = st;
		mask = W'((1 << st.sel) - 1);
		next_st.tick = 1'b0;
		if (tick_in) begin
			if ((st.cnt & mask) == mask) begin
				next_st.tick = 1'b1;
				next_st.cnt = '0;
				next_st.sel = div_sel;
			end else begin
				next_st.cnt = st.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			st <= '{cnt: '0, sel: DIV_RESET, tick: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign tick_out = st.tick;
endmodule
`default_nettype wire

//--- rtl/ccp_pkg.sv
// Package for the core clock and power mode controller
`default_nettype none
package ccp_pkg;
	// PLL multiplication factor and reference
	localparam int unsigned PLL_MULT       = 1275;
	localparam int unsigned REF_HZ         = 32768;
	localparam int unsigned SYS_HZ         = 40_000_000;
	localparam int unsigned SYS_NS         = 25;
	// Divider setting range and reset value
	localparam int unsigned DIV_W          = 3;
	localparam logic [2:0]  DIV_RESET      = 3'h3;
	localparam logic [2:0]  DIV_MAX        = 3'h7;
	// Wake times
	localparam int unsigned PAUSE_WAKE0_NS = 230;
	localparam int unsigned NAP_WAKE0_NS   = 283;
	localparam int unsigned WAKE7_NS       = 3000;
	localparam int unsigned SLEEP_WAKE_NS  = 1_230_000;
	localparam int unsigned STOP_WAKE_NS   = 1_450_000;
	// All times round down, never below one cycle
	function automatic int unsigned ns2cyc(input int unsigned ns);
		int unsigned c;
		c = ns / SYS_NS;
		return (c == 0) ? 1 : c;
	endfunction
	localparam int unsigned PAUSE_WAKE0_CYC = ns2cyc(PAUSE_WAKE0_NS);
	localparam int unsigned NAP_WAKE0_CYC   = ns2cyc(NAP_WAKE0_NS);
	localparam int unsigned WAKE7_CYC       = ns2cyc(WAKE7_NS);
	localparam int unsigned SLEEP_WAKE_CYC  = ns2cyc(SLEEP_WAKE_NS);
	localparam int unsigned STOP_WAKE_CYC   = ns2cyc(STOP_WAKE_NS);
	localparam int unsigned CNT_W           = 17;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 17'h0_0000;
	localparam logic [CNT_W-1:0] CNT_ONE    = 17'h0_0001;

	typedef enum logic [2:0] {
		CCP_ACTIVE, CCP_PAUSE, CCP_NAP, CCP_SLEEP, CCP_STOP
	} ccp_mode_t;

	typedef enum logic [1:0] {
		CCP_REF_INTOSC, CCP_REF_WATCH_CRYSTAL_OSCILLATOR, CCP_SRC_EXT
	} ccp_src_t;

	// Software-visible control word (PLL control register)
	typedef struct packed {
		ccp_src_t          src;
		logic [DIV_W-1:0]  core_clock_divider;
	} ccp_ctrl_t;

	// Domain enables handed to the rest of the chip
	typedef struct packed {
		logic core_en;
		logic periph_en;
		logic pll_en;
		logic watch_crystal_oscillator_timer_en;
		logic ext_irq_en;
	} ccp_pwr_t;
endpackage
`default_nettype wire

//--- verification/ccp_clock_src.sv
// Model of the PLL and external clock sources feeding the controller
`default_nettype none
module ccp_clock_src (
	input  wire logic clk_sys,
	output logic      pll_tick,
	output logic      ext_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph = 2'h0;
	// PLL outruns clk_sys, so it ticks every cycle
	assign pll_tick = 1'b1;
	assign ext_tick = ph == 2'h0;
	always @(posedge clk_sys) ph <= ph + 2'h1;
endmodule
`default_nettype wire

//--- verification/ccp_core_clock_power_assertions.sv
// Port checks for the core clock and power controller
`default_nettype none
module ccp_core_clock_power_assertions
	import ccp_pkg::*;
(
	input  wire logic               clk_sys,
	input  wire logic               resetn,
	input  wire logic               pll_locked,
	input  wire logic               ctrl_wr,
	input  wire ccp_pkg::ccp_ctrl_t ctrl_wdata,
	input  wire logic               wdog_reset_seen,
	input  wire ccp_pkg::ccp_ctrl_t pll_control_register,
	input  wire ccp_pkg::ccp_mode_t mode,
	input  wire ccp_pkg::ccp_pwr_t  pwr,
	input  wire logic               core_clock_tick,
	input  wire logic               pll_irq,
	input  wire logic               reset_status_register
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic lost;
	assign lost = !pll_locked && pll_control_register.src != CCP_SRC_EXT;
	ctrl_write_a: assert property (ctrl_wr |=>
		pll_control_register == $past(ctrl_wdata)) else $error("ctrl lost");
	halt_core_a: assert property (lost |=> !core_clock_tick)
		else $error("core ran unlocked");
	irq_raise_a: assert property (lost && pwr.pll_en |=> pll_irq)
		else $error("no pll irq");
	active_pwr_a: assert property (mode == CCP_ACTIVE |-> pwr == 5'h1F)
		else $error("active enables");
	pause_pwr_a: assert property (mode == CCP_PAUSE |-> pwr == 5'h0F)
		else $error("pause enables");
	nap_pwr_a: assert property (mode == CCP_NAP |-> pwr == 5'h07)
		else $error("nap enables");
	sleep_pwr_a: assert property (mode == CCP_SLEEP |-> pwr == 5'h03)
		else $error("sleep enables");
	wdog_flag_a: assert property (wdog_reset_seen |=> reset_status_register)
		else $error("watchdog flag");
	cover property (lost ##1 pll_irq);
	cover property (mode == CCP_STOP);
	cover property ($rose(pwr.core_en));
endmodule
bind ccp_core_clock_power ccp_core_clock_power_assertions u_chk (.clk_sys,
	.resetn, .pll_locked, .ctrl_wr, .ctrl_wdata, .wdog_reset_seen,
	.pll_control_register, .mode, .pwr, .core_clock_tick, .pll_irq,
	.reset_status_register);
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the core clock and power controller
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ccp_pkg::*;
	logic      clk_sys = 0, resetn = 0, lk = 1, cw = 0, mw = 0, wk = 0;
	logic      wdg = 0, clr = 0, pt, et, xt, irq, tick, st, waking;
	ccp_ctrl_t wd = '0, ctrl;
	ccp_mode_t md = CCP_ACTIVE, mode;
	ccp_pwr_t  pwr;
	int        errors = 0, samples_checked = 0, n;
	ccp_clock_src u_ccp_clock_src (.clk_sys, .pll_tick(pt), .ext_tick(et));
	ccp_core_clock_power #(.SLEEP_CYC(20), .STOP_CYC(20))
	u_ccp_core_clock_power (.clk_sys, .resetn, .pll_system_clock_tick(pt),
		.external_clock_input_tick(et), .pll_locked(lk), .ctrl_wr(cw),
		.ctrl_wdata(wd), .mode_wr(mw), .mode_wdata(md), .wake_req(wk),
		.wdog_reset_seen(wdg), .rst_status_clr(clr),
		.pll_control_register(ctrl), .mode, .pwr, .pll_ref_watch_crystal_oscillator(xt),
		.core_clock_tick(tick), .pll_irq(irq),
		.reset_status_register(st), .waking);
	initial forever #12.5 clk_sys = !clk_sys;
	task automatic cyc(int k);
		repeat (k) @(negedge clk_sys);
	endtask
	task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic measure();
		n = 0;
		repeat (256) begin
			cyc(1);
			if (tick === 1'b1) n++;
		end
	endtask
	task automatic set_ctrl(ccp_src_t s, logic [2:0] d);
		wd = '{s, d};
		cw = 1;
		cyc(1);
		cw = 0;
		cyc(140);
	endtask
	task automatic final_report();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic t_reset();
		chk("ctrl", 16'(ctrl), 16'({CCP_REF_INTOSC, 3'h3}));
		chk("pwr", 16'(pwr), 16'h001F);
		measure();
		chk("div3", 16'(n), 16'h0020);
	endtask
	task automatic t_lock();
		lk = 0;
		measure();
		chk("halt", 16'(n), 16'h0000);
		chk("irq", 16'(irq), 16'h0001);
		lk = 1;
		cyc(2);
		chk("irq", 16'(irq), 16'h0000);
	endtask
	task automatic t_div();
		for (int d = 0; d < 8; d++) begin
			set_ctrl(CCP_REF_INTOSC, 3'(d));
			measure();
			chk("rate", 16'(n), 16'(256 >> d));
		end
	endtask
	task automatic t_modes();
		int w;
		for (int m = 1; m < 5; m++) begin
			md = ccp_mode_t'(m);
			mw = 1;
			cyc(1);
			md = CCP_ACTIVE;
			cyc(2);
			chk("pwr", 16'(pwr), 16'(5'h1F >> m));
			chk("refuse", 16'(mode), 16'(m));
			mw = 0;
			wk = 1;
			cyc(1);
			wk = 0;
			chk("waking", 16'(waking), 16'h0001);
			w = 1;
			while (mode !== CCP_ACTIVE && w < 300) begin
				cyc(1);
				w++;
			end
			n = (m < 3) ? 120 : 20;
			chk("wake", 16'(w >= n && w <= n + 2), 16'h0001);
			chk("woke", 16'(waking), 16'h0000);
		end
	endtask
	task automatic t_wake0();
		int w;
		for (int m = 1; m < 3; m++) begin
			md = ccp_mode_t'(m);
			mw = 1;
			cyc(1);
			mw = 0;
			md = CCP_ACTIVE;
			wk = 1;
			cyc(1);
			wk = 0;
			w = 1;
			while (mode !== CCP_ACTIVE && w < 300) begin
				cyc(1);
				w++;
			end
			n = (m == 1) ? PAUSE_WAKE0_CYC : NAP_WAKE0_CYC;
			chk("wake0", 16'(w >= n && w <= n + 2), 16'h0001);
		end
	endtask
	task automatic t_rst2();
		wdg = 1;
		cyc(1);
		wdg = 0;
		resetn = 0;
		cyc(3);
		resetn = 1;
		cyc(2);
		chk("rctrl", 16'(ctrl), 16'({CCP_REF_INTOSC, DIV_RESET}));
		chk("rmode", 16'(mode), 16'(CCP_ACTIVE));
		chk("rwdog", 16'(st), 16'h0000);
		chk("rxtal", 16'(xt), 16'h0000);
		measure();
		chk("rdiv3", 16'(n), 16'h0020);
	endtask
	task automatic t_src();
		set_ctrl(CCP_REF_WATCH_CRYSTAL_OSCILLATOR, 3'h0);
		chk("watch_crystal_oscillator", 16'(xt), 16'h0001);
		set_ctrl(CCP_SRC_EXT, 3'h0);
		measure();
		chk("ext", 16'(n), 16'h0040);
		wdg = 1;
		cyc(1);
		wdg = 0;
		cyc(1);
		chk("wdog", 16'(st), 16'h0001);
		clr = 1;
		cyc(1);
		clr = 0;
		cyc(1);
		chk("wclr", 16'(st), 16'h0000);
		wdg = 1;
		clr = 1;
		cyc(1);
		wdg = 0;
		clr = 0;
		cyc(1);
		chk("wboth", 16'(st), 16'h0001);
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		final_report();
	end
	initial begin
		cyc(10);
		resetn = 1;
		cyc(2);
		t_reset();
		t_lock();
		t_div();
		t_modes();
		t_src();
		t_wake0();
		t_rst2();
		final_report();
	end
endmodule
`default_nettype wire
